// ==== hw/msl_device.sv ====
// Functional notes
// R1 - Host writes 0xC0 for data-rate mode; the device takes bit 6 set as FIFO-rate mode
// R2 - Host writes 0x80 for FIFO-rate mode; the device takes bit 6 clear as data-rate mode
// R3 - Host polls lock bit 6 at 0x12
// R4 - Frame high one or two strobe periods
// R5 - Configure, confirm lock, then frame reset
// R6 - Data-rate sync reference at most data/2^N
// R7 - FIFO-rate sync reference at most data/(8*2^N)
// R8 - Prefer FIFO-rate mode when N is three+
// R9 - Lock after (11+avg) times 64 cycles stable
// R10 - Lost bit 7 set when aligned device slips; the logic sets it only on a slip while locked
// R11 - Lost bit latched until status write
// R12 - Locked and lost drive active-low interrupt
// R13 - Control bit 3 selects sync sampling edge
// R14 - Resynchronize when phase error exceeds threshold
// R15 - Average phase over selected sample count
// R16 - Software picks largest tolerable averaging count
// R17 - Control bit 6 selects data or FIFO rate
// R18 - Data-rate frame reset at read pointer zero
// R19 - FIFO-rate frame rise loads start level
// R20 - Input FIFO holds eight entries
// R21 - Control bit 7 enables sync logic
// R22 - Averaging count is two to field value
// R23 - Resync clears lock until stable again
`timescale 1ns/10ps
module msl_device #(
  parameter int DATA_W = 16,
  parameter int DATA_DIV = 4,
  parameter int PH_THRESH = 1
) (
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  msl_if.dev link,
  output logic [DATA_W-1:0] o_dac_data,
  output logic o_locked
);
  localparam int CG_W = 10;
  localparam int LK_W = 11;
  localparam logic [CG_W-1:0] DR_LAST = CG_W'(DATA_DIV - 1);
  localparam logic [CG_W-1:0] FR_LAST = CG_W'(DATA_DIV * msl_pkg::FIFO_DEPTH - 1);

  logic [2:0] ref_reg, ref_next, stb_reg, stb_next, frm_reg, frm_next;
  logic [1:0] req_reg, req_next;
  logic [DATA_W-1:0] din1_reg, din1_next, din2_reg, din2_next;
  logic [7:0] ctrl_reg, ctrl_next, irqen_reg, irqen_next, rdata_reg, rdata_next;
  logic ack_reg, ack_next, locked_reg, locked_next, lost_reg, lost_next;
  logic irq_n_reg, irq_n_next, aligned_reg, aligned_next;
  logic [CG_W-1:0] cg_reg, cg_next;
  logic signed [19:0] acc_reg, acc_next;
  logic [7:0] nsmp_reg, nsmp_next;
  logic [LK_W-1:0] lk_reg, lk_next;
  logic [DATA_W-1:0] mem [msl_pkg::FIFO_DEPTH];
  logic [2:0] wp_reg, wp_next, rp_reg, rp_next;
  logic pend_reg, pend_next;
  logic [DATA_W-1:0] out_reg, out_next;
  logic mem_we;

  logic enable, fifo_mode, sync_evt, resync, rd_tick, stb_rise, frm_rise;
  logic [CG_W-1:0] cg_last;
  logic [2:0] avg_fld;
  logic signed [CG_W+1:0] ph_s;
  logic signed [19:0] acc_sum, avg_ph;
  logic [LK_W-1:0] lk_target;

  always_comb
  begin
    enable = ctrl_reg[msl_pkg::CTRL_EN_BIT];
    fifo_mode = ctrl_reg[msl_pkg::CTRL_MODE_BIT]; // R17
    avg_fld = ctrl_reg[msl_pkg::CTRL_AVG_LSB +: msl_pkg::AVG_W];
    cg_last = fifo_mode ? FR_LAST : DR_LAST; // R20
    // The sync reference is sampled on the rising or falling transition.
    sync_evt = ctrl_reg[msl_pkg::CTRL_EDGE_BIT] ? (ref_reg[1] & ~ref_reg[2])
                                                : (~ref_reg[1] & ref_reg[2]); // R13
    stb_rise = stb_reg[1] & ~stb_reg[2];
    frm_rise = frm_reg[1] & ~frm_reg[2];
    // Phase folds to a signed error so jitter around zero does not wrap.
    ph_s = (cg_reg > (cg_last >> 1)) ? $signed({2'b00, cg_reg}) - $signed({2'b00, cg_last})
                                         - 12'sd1
                                       : $signed({2'b00, cg_reg});
    acc_sum = acc_reg + 20'(ph_s);
    avg_ph = acc_sum >>> avg_fld; // R15 R22
    lk_target = LK_W'((msl_pkg::LOCK_BASE + int'(avg_fld)) * msl_pkg::LOCK_UNIT); // R9
    resync = 1'b0;
    ref_next = {ref_reg[1:0], link.shared_sync_reference};
    stb_next = {stb_reg[1:0], link.input_data_strobe};
    frm_next = {frm_reg[1:0], link.frame_marker};
    req_next = {req_reg[0], link.reg_req};
    din1_next = link.data;
    din2_next = din1_reg;
    cg_next = (cg_reg == cg_last) ? '0 : cg_reg + 1'b1;
    acc_next = acc_reg;
    nsmp_next = nsmp_reg;
    aligned_next = aligned_reg;
    lk_next = lk_reg;
    locked_next = locked_reg;
    lost_next = lost_reg;
    ctrl_next = ctrl_reg;
    irqen_next = irqen_reg;
    rdata_next = rdata_reg;
    ack_next = ack_reg;
    // A new setting restarts alignment, so a lock from the old setting cannot pass the poll.
    if (!enable || (req_reg[1] && !ack_reg && link.reg_wr
                    && link.reg_addr == msl_pkg::SYNC_CTRL_ADDR)) // R23 R5
    begin
      aligned_next = 1'b0;
      locked_next = 1'b0; // R21
      acc_next = '0;
      nsmp_next = '0;
      lk_next = '0;
    end
    else if (sync_evt)
    begin
      if (!aligned_reg)
      begin
        resync = 1'b1;
      end
      else if (nsmp_reg + 8'h01 == (8'h01 << avg_fld))
      begin
        acc_next = '0;
        nsmp_next = '0;
        if (avg_ph > PH_THRESH || avg_ph < -PH_THRESH)
        begin
          resync = 1'b1; // R14
        end
      end
      else
      begin
        acc_next = acc_sum;
        nsmp_next = nsmp_reg + 8'h01;
      end
    end
    if (resync)
    begin
      // The sync edge marks phase zero of the clock generator.
      cg_next = (cg_last == '0) ? '0 : CG_W'(1);
      aligned_next = 1'b1;
      acc_next = '0;
      nsmp_next = '0;
      lk_next = '0;
      locked_next = 1'b0; // R23
    end
    else if (aligned_next && !locked_reg)
    begin
      lk_next = lk_reg + 1'b1;
      if (lk_reg + 1'b1 >= lk_target)
      begin
        locked_next = 1'b1; // R9 R3
      end
    end
    // Register port: four-phase handshake with the synchronised request.
    if (req_reg[1] && !ack_reg)
    begin
      ack_next = 1'b1;
      rdata_next = 8'h00;
      if (link.reg_wr)
      begin
        if (link.reg_addr == msl_pkg::SYNC_CTRL_ADDR)
        begin
          ctrl_next = link.reg_wdata;
        end
        if (link.reg_addr == msl_pkg::IRQ_EN_ADDR)
        begin
          irqen_next = link.reg_wdata;
        end
        if (link.reg_addr == msl_pkg::SYNC_STAT_ADDR)
        begin
          lost_next = 1'b0; // R11
        end
      end
      else if (link.reg_addr == msl_pkg::SYNC_CTRL_ADDR)
      begin
        rdata_next = ctrl_reg;
      end
      else if (link.reg_addr == msl_pkg::IRQ_EN_ADDR)
      begin
        rdata_next = irqen_reg;
      end
      else if (link.reg_addr == msl_pkg::SYNC_STAT_ADDR)
      begin
        rdata_next[msl_pkg::STAT_LOCK_BIT] = locked_reg;
        rdata_next[msl_pkg::STAT_LOST_BIT] = lost_reg;
      end
    end
    else if (!req_reg[1] && ack_reg)
    begin
      ack_next = 1'b0;
    end
    // A slip seen in the clearing cycle still latches.
    if (resync && locked_reg)
    begin
      lost_next = 1'b1; // R10 R11
    end
    irq_n_next = ~((locked_next & irqen_reg[msl_pkg::STAT_LOCK_BIT])
                 | (lost_next & irqen_reg[msl_pkg::STAT_LOST_BIT])); // R12
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_sys_rst)
    begin
      ref_reg <= '0;
      stb_reg <= '0;
      frm_reg <= '0;
      req_reg <= '0;
      din1_reg <= '0;
      din2_reg <= '0;
      cg_reg <= '0;
      acc_reg <= '0;
      nsmp_reg <= '0;
      aligned_reg <= 1'b0;
      lk_reg <= '0;
      locked_reg <= 1'b0;
      lost_reg <= 1'b0;
      ctrl_reg <= msl_pkg::CTRL_RESET;
      irqen_reg <= msl_pkg::IRQ_EN_RESET;
      rdata_reg <= 8'h00;
      ack_reg <= 1'b0;
      irq_n_reg <= 1'b1;
    end
    else
    begin
      ref_reg <= ref_next;
      stb_reg <= stb_next;
      frm_reg <= frm_next;
      req_reg <= req_next;
      din1_reg <= din1_next;
      din2_reg <= din2_next;
      cg_reg <= cg_next;
      acc_reg <= acc_next;
      nsmp_reg <= nsmp_next;
      aligned_reg <= aligned_next;
      lk_reg <= lk_next;
      locked_reg <= locked_next;
      lost_reg <= lost_next;
      ctrl_reg <= ctrl_next;
      irqen_reg <= irqen_next;
      rdata_reg <= rdata_next;
      ack_reg <= ack_next;
      irq_n_reg <= irq_n_next;
    end
  end

  // Input FIFO: written on strobe rises, read once per data period.
  always_comb
  begin
    rd_tick = (cg_reg & CG_W'(DATA_DIV - 1)) == '0;
    mem_we = stb_rise;
    wp_next = stb_rise ? wp_reg + 1'b1 : wp_reg;
    rp_next = rd_tick ? rp_reg + 1'b1 : rp_reg;
    pend_next = pend_reg;
    out_next = rd_tick ? mem[rp_reg] : out_reg;
    if (frm_rise && fifo_mode)
    begin
      wp_next = msl_pkg::FIFO_START_LVL; // R19
    end
    else if (frm_rise)
    begin
      pend_next = 1'b1;
    end
    if (pend_reg && !fifo_mode && rd_tick && rp_reg == 3'h0)
    begin
      wp_next = msl_pkg::FIFO_PHASE_OFS; // R18 R5
      pend_next = 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (mem_we)
    begin
      mem[wp_reg] <= din2_reg; // R20
    end
    if (i_sys_rst)
    begin
      wp_reg <= msl_pkg::FIFO_START_LVL;
      rp_reg <= 3'h0;
      pend_reg <= 1'b0;
      out_reg <= '0;
    end
    else
    begin
      wp_reg <= wp_next;
      rp_reg <= rp_next;
      pend_reg <= pend_next;
      out_reg <= out_next;
    end
  end

  assign link.reg_ack = ack_reg;
  assign link.reg_rdata = rdata_reg;
  assign link.irq_n = irq_n_reg;
  assign o_dac_data = out_reg;
  assign o_locked = locked_reg;
endmodule

// ==== hw/msl_if.sv ====
`timescale 1ns/10ps
interface msl_if #(parameter int DATA_W = 16);
  logic shared_sync_reference;
  logic input_data_strobe;
  logic frame_marker;
  logic [DATA_W-1:0] data;
  logic reg_req;
  logic reg_wr;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_ack;
  logic [7:0] reg_rdata;
  logic irq_n;
  modport dev (
    input shared_sync_reference, input_data_strobe, frame_marker, data,
    input reg_req, reg_wr, reg_addr, reg_wdata,
    output reg_ack, reg_rdata, irq_n
  );
  modport src (
    output shared_sync_reference, input_data_strobe, frame_marker, data,
    output reg_req, reg_wr, reg_addr, reg_wdata,
    input reg_ack, reg_rdata, irq_n
  );
endinterface

// ==== hw/msl_pkg.sv ====
package msl_pkg;
  localparam logic [7:0] SYNC_CTRL_ADDR = 8'h10;
  localparam logic [7:0] SYNC_STAT_ADDR = 8'h12;
  localparam logic [7:0] IRQ_EN_ADDR = 8'h13;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] IRQ_EN_RESET = 8'h00;
  localparam logic [7:0] CFG_DATA_RATE = 8'hC0;
  localparam logic [7:0] CFG_FIFO_RATE = 8'h80;
  localparam int CTRL_EN_BIT = 7;
  localparam int CTRL_MODE_BIT = 6;
  localparam int CTRL_EDGE_BIT = 3;
  localparam int CTRL_AVG_LSB = 0;
  localparam int AVG_W = 3;
  localparam int STAT_LOCK_BIT = 6;
  localparam int STAT_LOST_BIT = 7;
  localparam int LOCK_BASE = 11;
  localparam int LOCK_UNIT = 64;
  localparam int FIFO_DEPTH = 8;
  localparam logic [2:0] FIFO_PHASE_OFS = 3'h4;
  localparam logic [2:0] FIFO_START_LVL = 3'h4;
  localparam logic [11:0] HOST_CMD_ADDR = 12'h000;
  localparam logic [11:0] HOST_STAT_ADDR = 12'h004;
  localparam int CMD_START_BIT = 0;
  localparam int CMD_MODE_BIT = 1;
  localparam int CMD_EDGE_BIT = 2;
  localparam int CMD_AVG_LSB = 3;
  localparam int CMD_BYTE_BIT = 6;
  localparam logic [31:0] CMD_RESET = 32'h0000_0000;
  typedef enum logic [4:0] {
    MSL_IDLE = 5'b00001,
    MSL_CFG = 5'b00010,
    MSL_POLL = 5'b00100,
    MSL_FRAME = 5'b01000,
    MSL_WAIT = 5'b10000
  } msl_host_state_t;
endpackage

// ==== hw/msl_source.sv ====
`timescale 1ns/10ps
module msl_source #(
  parameter int DATA_W = 16,
  parameter int STB_HALF = 2,
  parameter int SYNC_HALF = 16
) (
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  msl_if.src link
);
  msl_pkg::msl_host_state_t st_reg, st_next;
  logic [31:0] cmd_reg, cmd_next, prdata_reg, prdata_next;
  logic pready_reg, pready_next, pslverr_reg, pslverr_next;
  logic busy_reg, busy_next, done_reg, done_next, lost_reg, lost_next;
  logic [1:0] ack_reg, ack_next, irq_reg, irq_next;
  logic req_reg, req_next, wr_reg, wr_next, frame_reg, frame_next;
  logic [7:0] addr_reg, addr_next, wdata_reg, wdata_next;
  logic [7:0] sdiv_reg, sdiv_next, ydiv_reg, ydiv_next;
  logic stb_reg, stb_next, sref_reg, sref_next;
  logic [1:0] fcnt_reg, fcnt_next;
  logic [DATA_W-1:0] data_reg, data_next;
  logic stb_rise, acc, cfg_byte;
  logic [7:0] cfg;

  always_comb
  begin
    acc = i_psel && i_penable && !pready_reg;
    cfg = cmd_reg[msl_pkg::CMD_MODE_BIT] ? msl_pkg::CFG_FIFO_RATE : msl_pkg::CFG_DATA_RATE;
    cfg[msl_pkg::CTRL_EDGE_BIT] = cmd_reg[msl_pkg::CMD_EDGE_BIT];
    cfg[msl_pkg::CTRL_AVG_LSB +: msl_pkg::AVG_W] = cmd_reg[msl_pkg::CMD_AVG_LSB +: 3];
    cfg_byte = cmd_reg[msl_pkg::CMD_BYTE_BIT];
    // Strobe and sync reference come from dividers of the local clock.
    stb_rise = (sdiv_reg == 8'(STB_HALF - 1)) && !stb_reg;
    sdiv_next = (sdiv_reg == 8'(STB_HALF - 1)) ? 8'h00 : sdiv_reg + 8'h01;
    stb_next = (sdiv_reg == 8'(STB_HALF - 1)) ? ~stb_reg : stb_reg;
    ydiv_next = (ydiv_reg == 8'(SYNC_HALF - 1)) ? 8'h00 : ydiv_reg + 8'h01; // R6 R7 R8
    sref_next = (ydiv_reg == 8'(SYNC_HALF - 1)) ? ~sref_reg : sref_reg;
    data_next = stb_rise ? data_reg + 1'b1 : data_reg;
    ack_next = {ack_reg[0], link.reg_ack};
    irq_next = {irq_reg[0], link.irq_n};
    st_next = st_reg;
    cmd_next = cmd_reg;
    busy_next = busy_reg;
    done_next = done_reg;
    lost_next = lost_reg;
    req_next = req_reg;
    wr_next = wr_reg;
    addr_next = addr_reg;
    wdata_next = wdata_reg;
    frame_next = frame_reg;
    fcnt_next = fcnt_reg;
    pready_next = acc;
    pslverr_next = 1'b0;
    prdata_next = 32'h0000_0000;
    if (acc)
    begin
      if (i_paddr == msl_pkg::HOST_CMD_ADDR)
      begin
        prdata_next = cmd_reg;
        if (i_pwrite)
        begin
          cmd_next = i_pwdata;
        end
      end
      else if (i_paddr == msl_pkg::HOST_STAT_ADDR)
      begin
        prdata_next = {28'h000_0000, ~irq_reg[1], lost_reg, done_reg, busy_reg};
      end
      else
      begin
        pslverr_next = 1'b1;
      end
    end
    unique case (st_reg)
      msl_pkg::MSL_IDLE:
      begin
        if (cmd_reg[msl_pkg::CMD_START_BIT])
        begin
          cmd_next[msl_pkg::CMD_START_BIT] = 1'b0;
          busy_next = 1'b1;
          done_next = 1'b0;
          req_next = 1'b1;
          wr_next = 1'b1;
          addr_next = msl_pkg::SYNC_CTRL_ADDR;
          wdata_next = cfg; // R1 R2
          st_next = msl_pkg::MSL_CFG;
        end
      end
      msl_pkg::MSL_CFG, msl_pkg::MSL_POLL:
      begin
        if (req_reg && ack_reg[1])
        begin
          req_next = 1'b0;
          if (st_reg == msl_pkg::MSL_POLL)
          begin
            lost_next = link.reg_rdata[msl_pkg::STAT_LOST_BIT];
            if (link.reg_rdata[msl_pkg::STAT_LOCK_BIT])
            begin
              st_next = msl_pkg::MSL_WAIT; // R3 R5
            end
          end
        end
        else if (!req_reg && !ack_reg[1])
        begin
          req_next = 1'b1;
          wr_next = 1'b0;
          addr_next = msl_pkg::SYNC_STAT_ADDR;
          st_next = msl_pkg::MSL_POLL;
        end
      end
      msl_pkg::MSL_WAIT:
      begin
        if (stb_rise && !ack_reg[1])
        begin
          frame_next = 1'b1;
          fcnt_next = cfg_byte ? 2'h2 : 2'h1; // R4
          st_next = msl_pkg::MSL_FRAME;
        end
      end
      msl_pkg::MSL_FRAME:
      begin
        if (stb_rise)
        begin
          fcnt_next = fcnt_reg - 2'h1;
          if (fcnt_reg == 2'h1)
          begin
            frame_next = 1'b0;
            busy_next = 1'b0;
            done_next = 1'b1;
            st_next = msl_pkg::MSL_IDLE;
          end
        end
      end
    endcase
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_sys_rst)
    begin
      st_reg <= msl_pkg::MSL_IDLE;
      cmd_reg <= msl_pkg::CMD_RESET;
      prdata_reg <= 32'h0000_0000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
      lost_reg <= 1'b0;
      ack_reg <= 2'b00;
      irq_reg <= 2'b11;
      req_reg <= 1'b0;
      wr_reg <= 1'b0;
      addr_reg <= 8'h00;
      wdata_reg <= 8'h00;
      frame_reg <= 1'b0;
      fcnt_reg <= 2'h0;
      sdiv_reg <= 8'h00;
      ydiv_reg <= 8'h00;
      stb_reg <= 1'b0;
      sref_reg <= 1'b0;
      data_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
      cmd_reg <= cmd_next;
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      busy_reg <= busy_next;
      done_reg <= done_next;
      lost_reg <= lost_next;
      ack_reg <= ack_next;
      irq_reg <= irq_next;
      req_reg <= req_next;
      wr_reg <= wr_next;
      addr_reg <= addr_next;
      wdata_reg <= wdata_next;
      frame_reg <= frame_next;
      fcnt_reg <= fcnt_next;
      sdiv_reg <= sdiv_next;
      ydiv_reg <= ydiv_next;
      stb_reg <= stb_next;
      sref_reg <= sref_next;
      data_reg <= data_next;
    end
  end

  assign o_prdata = prdata_reg;
  assign o_pready = pready_reg;
  assign o_pslverr = pslverr_reg;
  assign link.shared_sync_reference = sref_reg;
  assign link.input_data_strobe = stb_reg;
  assign link.frame_marker = frame_reg;
  assign link.data = data_reg;
  assign link.reg_req = req_reg;
  assign link.reg_wr = wr_reg;
  assign link.reg_addr = addr_reg;
  assign link.reg_wdata = wdata_reg;
endmodule

// ==== tb/msl_checker_sva.sv ====
`timescale 1ns/10ps
module msl_checker_sva #(
  parameter int STB_HALF = 2
) (
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic frame_marker,
  input wire logic reg_req,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_ack,
  input wire logic [7:0] reg_rdata,
  input wire logic irq_n
);
  logic [7:0] frame_cnt_reg, frame_cnt_next;
  logic lock_seen_reg, lock_seen_next, ien_seen_reg, ien_seen_next;

  // A ctrl write restarts alignment, so an earlier lock read no longer licenses a frame.
  always_comb
  begin
    frame_cnt_next = frame_marker ? frame_cnt_reg + 8'h01 : 8'h00;
    lock_seen_next = lock_seen_reg;
    ien_seen_next = ien_seen_reg;
    if (reg_ack && !reg_wr && reg_addr == msl_pkg::SYNC_STAT_ADDR
        && reg_rdata[msl_pkg::STAT_LOCK_BIT])
      lock_seen_next = 1'b1;
    if (reg_ack && reg_wr && reg_addr == msl_pkg::SYNC_CTRL_ADDR)
      lock_seen_next = 1'b0;
    if (reg_req && reg_wr && reg_addr == msl_pkg::IRQ_EN_ADDR)
      ien_seen_next = 1'b1;
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_sys_rst)
    begin
      frame_cnt_reg <= 8'h00;
      lock_seen_reg <= 1'b0;
      ien_seen_reg <= 1'b0;
    end
    else
    begin
      frame_cnt_reg <= frame_cnt_next;
      lock_seen_reg <= lock_seen_next;
      ien_seen_reg <= ien_seen_next;
    end
  end

  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_sys_rst);

  property p_ack_rise;
    $rose(reg_req) |-> ##[2:4] reg_ack;
  endproperty
  a_ack_rise: assert property (p_ack_rise) else $error("register ack late");
  property p_ack_hold;
    reg_req && reg_ack |=> reg_ack;
  endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("ack dropped early");
  property p_ack_drop;
    $fell(reg_req) |-> ##[1:5] !reg_ack;
  endproperty
  a_ack_drop: assert property (p_ack_drop) else $error("ack stuck high");
  property p_ack_idle;
    !reg_req && !reg_ack |=> !reg_ack;
  endproperty
  a_ack_idle: assert property (p_ack_idle) else $error("spurious ack");
  property p_req_hold;
    reg_req && !reg_ack |=> reg_req && $stable(reg_addr) && $stable(reg_wr)
      && $stable(reg_wdata);
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("request changed");
  property p_rdata_stable;
    reg_ack && $past(reg_ack) |-> $stable(reg_rdata);
  endproperty
  a_rdata_stable: assert property (p_rdata_stable) else $error("rdata moved");
  property p_ctrl_value;
    reg_req && reg_wr && reg_addr == msl_pkg::SYNC_CTRL_ADDR
      |-> reg_wdata[7] && reg_wdata[5:4] == 2'b00;
  endproperty
  a_ctrl_value: assert property (p_ctrl_value) else $error("bad ctrl value");
  property p_frame_len;
    $fell(frame_marker) |-> frame_cnt_reg == 2 * STB_HALF || frame_cnt_reg == 4 * STB_HALF;
  endproperty
  a_frame_len: assert property (p_frame_len) else $error("frame width wrong");
  property p_frame_order;
    $rose(frame_marker) |-> lock_seen_reg;
  endproperty
  a_frame_order: assert property (p_frame_order) else $error("frame before lock");
  property p_irq_quiet;
    !ien_seen_reg |-> irq_n;
  endproperty
  a_irq_quiet: assert property (p_irq_quiet) else $error("irq while masked");
endmodule

// ==== tb/tb_top.sv ====
`timescale 1ns/10ps
module tb_top;
  localparam int STB_HALF = 2;
  typedef struct {logic [31:0] cmd; logic [7:0] ctrl; int flen;} msl_row_t;
  logic i_sys_clk, i_sys_rst, psel, penable, pwrite, pready, pslverr, o_locked, locked_d;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] dac_data;
  logic [7:0] last_ctrl;
  logic err, ack_d;
  int bad_count = 0;
  int n_tests = 0;
  int frame_len = 0;
  int frame_run = 0;
  int lock_cyc = -1;
  int cyc = 0;
  // Command word: start, mode, edge, averaging, byte framing; ctrl and frame cycles expected.
  msl_row_t rows[4] = '{'{32'h0000_0001, 8'hC0, 4}, '{32'h0000_0047, 8'h88, 8},
    '{32'h0000_0009, 8'hC1, 4}, '{32'h0000_003B, 8'h87, 4}};

  msl_if msl_if_i ();
  msl_source #(.DATA_W(16), .STB_HALF(STB_HALF), .SYNC_HALF(16)) msl_source_i (
    .i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .link(msl_if_i.src));
  msl_device #(.DATA_DIV(4), .PH_THRESH(1)) msl_device_i (
    .i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .link(msl_if_i.dev),
    .o_dac_data(dac_data), .o_locked(o_locked));
  msl_checker_sva #(.STB_HALF(STB_HALF)) msl_checker_sva_i (
    .i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .frame_marker(msl_if_i.frame_marker),
    .reg_req(msl_if_i.reg_req), .reg_wr(msl_if_i.reg_wr), .reg_addr(msl_if_i.reg_addr),
    .reg_wdata(msl_if_i.reg_wdata), .reg_ack(msl_if_i.reg_ack),
    .reg_rdata(msl_if_i.reg_rdata), .irq_n(msl_if_i.irq_n));

  initial
  begin
    i_sys_clk = 1'b0;
    forever #2.5 i_sys_clk = ~i_sys_clk;
  end

  // Watches the wire: frame width, last ctrl value written, cycles from ctrl write to lock.
  always @(posedge i_sys_clk)
  begin
    if (msl_if_i.frame_marker === 1'b1)
      frame_run++;
    else if (frame_run != 0)
    begin
      frame_len = frame_run;
      frame_run = 0;
    end
    if (msl_if_i.reg_ack === 1'b1 && ack_d !== 1'b1 && msl_if_i.reg_wr === 1'b1
        && msl_if_i.reg_addr === msl_pkg::SYNC_CTRL_ADDR)
    begin
      last_ctrl = msl_if_i.reg_wdata;
      cyc = 0;
    end
    else
      cyc++;
    if (o_locked === 1'b1 && locked_d !== 1'b1)
      lock_cyc = cyc;
    locked_d = o_locked;
    ack_d = msl_if_i.reg_ack;
  end

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("compares %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // One idle cycle follows each transfer, so psel is never lowered and raised in one step.
  task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wd;
    @(posedge i_sys_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge i_sys_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge i_sys_clk);
  endtask

  task automatic do_reset(input int n);
    i_sys_rst <= 1'b1;
    repeat (n) @(posedge i_sys_clk);
    chk("prdata", prdata, 32'h0);
    chk("pready", 32'(pready), 32'h0);
    chk("irq_n", 32'(msl_if_i.irq_n), 32'h1);
    chk("locked", 32'(o_locked), 32'h0);
    chk("dac_data", 32'(dac_data), 32'h0);
    i_sys_rst <= 1'b0;
    $display("reset test done");
  endtask

  task automatic run_row(input msl_row_t r);
    int n;
    int lo;
    int hi;
    n = 0;
    lo = (11 + int'(r.cmd[5:3])) * 64;
    hi = (11 + int'(r.cmd[5:3])) * 128 + 64;
    lock_cyc = -1;
    apb(1'b1, msl_pkg::HOST_CMD_ADDR, r.cmd);
    chk("cmd_err", 32'(err), 32'h0);
    do
    begin
      apb(1'b0, msl_pkg::HOST_STAT_ADDR, 32'h0);
      n++;
    end while (rd[1] !== 1'b1 && n < 3000);
    chk("done", 32'(rd[1]), 32'h1);
    chk("ctrl", 32'(last_ctrl), 32'(r.ctrl));
    chk("locked", 32'(o_locked), 32'h1);
    chk("frame_len", 32'(frame_len), 32'(r.flen));
    chk("lost", 32'(rd[2]), 32'h0);
    chk("lock_time", 32'(lock_cyc >= lo && lock_cyc <= hi), 32'h1);
    $display("row test done cmd %h", r.cmd);
  endtask

  initial
  begin
    #400_000;
    bad_count++;
    conclude();
  end

  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    i_sys_rst = 1'b1;
    do_reset(16);
    repeat (1500) @(posedge i_sys_clk);
    chk("locked_idle", 32'(o_locked), 32'h0);
    foreach (rows[i])
      run_row(rows[i]);
    apb(1'b0, 12'h008, 32'h0);
    chk("unmapped_rd", rd, 32'h0);
    apb(1'b1, 12'h00C, 32'h0000_0001);
    chk("unmapped_err", 32'(err), 32'h1);
    apb(1'b1, msl_pkg::HOST_CMD_ADDR, rows[3].cmd);
    repeat (300) @(posedge i_sys_clk);
    do_reset(4);
    @(posedge i_sys_clk);
    apb(1'b0, msl_pkg::HOST_STAT_ADDR, 32'h0);
    chk("status_rst", rd, 32'h0);
    run_row(rows[3]);
    conclude();
  end
endmodule
